// ===== logic/riv_pkg.sv
/*
 * riv_pkg: register indices, implemented-bit masks, initial values and the
 * reset-class enumeration of the register initial-value controller.
 * Assumes an APB slave with 32-bit data, one register byte per aligned word.
 */
package riv_pkg;

    localparam int NREG = 29;

    // register index; byte address is index * 4
    localparam logic [4:0] REG_PC_LO   = 5'h00;
    localparam logic [4:0] REG_PC_HI   = 5'h01;
    localparam logic [4:0] REG_STATUS  = 5'h02;
    localparam logic [4:0] REG_OPTION  = 5'h03;
    localparam logic [4:0] REG_TRIS0   = 5'h04;
    localparam logic [4:0] REG_LAT_A   = 5'h08;
    localparam logic [4:0] REG_LAT_B   = 5'h09;
    localparam logic [4:0] REG_INT_CTL = 5'h0A;
    localparam logic [4:0] REG_PFLAG   = 5'h0B;
    localparam logic [4:0] REG_PENAB   = 5'h0C;
    localparam logic [4:0] REG_PERIOD  = 5'h0D;
    localparam logic [4:0] REG_TXCTL   = 5'h0E;
    localparam logic [4:0] REG_RXCTL   = 5'h0F;
    localparam logic [4:0] REG_CMP     = 5'h10;
    localparam logic [4:0] REG_OSC     = 5'h11;
    localparam logic [4:0] REG_WDOG    = 5'h12;
    localparam logic [4:0] REG_LVD     = 5'h13;
    localparam logic [4:0] REG_T1CTL   = 5'h14;
    localparam logic [4:0] REG_POWER   = 5'h15;
    localparam logic [4:0] REG_SSP     = 5'h16;
    localparam logic [4:0] REG_CAPT    = 5'h17;
    localparam logic [4:0] REG_CONV    = 5'h18;
    localparam logic [4:0] REG_T0_CNT  = 5'h19;
    localparam logic [4:0] REG_PTR     = 5'h1A;
    localparam logic [4:0] REG_WORK    = 5'h1B;
    localparam logic [4:0] REG_CLASS   = 5'h1C;
    localparam int         NUM_TRIS    = 4;

    // implemented bits, highest index first
    localparam logic [NREG-1:0][7:0] IMPL_MASK = {
        8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h7F,
        8'h3F, 8'h1F, 8'h7F, 8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h1F, 8'hFF};
    // software-writable bits: counter low byte, class and status[4:3] are not
    localparam logic [NREG-1:0][7:0] WR_MASK = {
        8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h7F,
        8'h3F, 8'h1F, 8'h7F, 8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hE7,
        8'h1F, 8'h00};
    // image after the asynchronous reset (power-on values, unknowns as zero)
    localparam logic [NREG-1:0][7:0] RST_IMAGE = {
        8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00,
        8'h05, 8'h08, 8'h08, 8'h07, 8'h00, 8'h02, 8'hFF, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h18,
        8'h00, 8'h00};

    localparam logic [7:0]  VAL_ONES    = 8'hFF;
    localparam logic [7:0]  VAL_TXCTL   = 8'h02;
    localparam logic [7:0]  VAL_CMP     = 8'h07;
    localparam logic [7:0]  VAL_OSC     = 8'h08;
    localparam logic [7:0]  VAL_WDOG    = 8'h08;
    localparam logic [7:0]  VAL_LVD     = 8'h05;
    localparam logic [7:0]  CLR_LAT_A   = 8'h2F;
    localparam logic [7:0]  CLR_LAT_B   = 8'h3F;
    localparam logic [12:0] PC_RESET    = 13'h0000;
    localparam logic [12:0] PC_VECTOR   = 13'h0004;
    localparam logic [12:0] PC_STEP     = 13'h0001;
    localparam int          BIT_GLB_EN  = 7;
    localparam int          BIT_TXIDLE  = 1;
    localparam int          BIT_POR     = 1;
    localparam int          BIT_BOR     = 0;
    localparam int          BIT_PWR_HI  = 2;

    // request bit positions of the synchronised cause inputs
    localparam int REQ_POR   = 0;
    localparam int REQ_BOR   = 1;
    localparam int REQ_PIN   = 2;
    localparam int REQ_WDT   = 3;
    localparam int REQ_WWAKE = 4;
    localparam int REQ_IWAKE = 5;
    localparam int REQ_SLEEP = 6;
    localparam int NUM_REQ   = 7;

    typedef enum logic [2:0] {
        CLS_NONE, CLS_POWER, CLS_BROWN, CLS_PIN, CLS_WDT, CLS_WDT_WAKE, CLS_INT_WAKE
    } riv_class_t;

    typedef struct packed {
        logic [NUM_REQ-2:0]     req_prev;
        logic [NREG-1:0][7:0]   regs;
        logic                   pc_load;
        logic [12:0]            pc_target;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
    } riv_state_t;

endpackage : riv_pkg

// ===== logic/riv_sync.sv
/*
 * riv_sync: two-flop synchroniser for a bus of independent levels.
 * Assumes each bit is a slow level, stable for several clocks.
 */
`timescale 1ns/1ns
`default_nettype none
module riv_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;

    if (WIDTH < 1) begin : g_width_check
        $error("riv_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage    <= '0;
            sync_out <= '0;
        end else begin
            stage    <= async_in;
            sync_out <= stage;
        end
    end
endmodule : riv_sync
`default_nettype wire

// ===== logic/riv_init_ctrl.sv
/*
 * riv_init_ctrl: applies the per-class initial values to the special
 * function registers on reset release or wake-up and redirects the
 * program counter; registers are reached over APB.
 * Assumes cause requests are asynchronous levels that fall on release,
 * pc_now and the wake flag vectors come from the core on pclk.
 */
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - counter low byte: 0000h on resets, next address on wake-up
// - interrupt wake with global enable set loads vector 0004h
// - wake-up ORs the cause flags into interrupt and peripheral flags
// - status: 0001 1xxx power, 000q quuu pin/watchdog, uuuq quuu wake
// - option register all ones on resets, kept on wake-up
// - port direction registers all ones on resets, kept on wake-up
// - port A latch bits 5 and 3:0, port B latch bits 5:0 cleared on resets, rest kept
// - interrupt control upper seven bits cleared on resets, bit 0 kept
// - peripheral flags and enables cleared on resets, enables kept on wake
// - timer-2 period forced all ones on every class, wake included
// - transmit control 0000 -010 on resets; wake forces bit 1 high
// - comparator control 0000 0111 on resets, kept on wake-up
// - oscillator control -000 1000 on resets, kept on wake-up
// - watchdog control 0 1000 on resets, kept on wake-up
// - low-voltage detect control 00 0101 on resets, kept on wake
// - timer-1 control cleared only on power-on or brown-out
// - serial, capture and converter controls cleared on resets
// - receive control 0000 000x on resets, bit 0 kept
// - working, timer, pointer registers untouched by every class
// - power control 1qq on power-on/brown-out, kept otherwise
// - counter high latch cleared on resets, kept on wake-up
// - unimplemented bits always read as zero
// - power-on status bit cleared on power-on only
module riv_init_ctrl
    import riv_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        por_req,
    input  wire logic        bor_req,
    input  wire logic        pin_req,
    input  wire logic        wdt_req,
    input  wire logic        wdt_wake_req,
    input  wire logic        int_wake_req,
    input  wire logic        core_sleeping,
    input  wire logic [12:0] pc_now,
    input  wire logic [7:0]  wake_interrupt_control_flags,
    input  wire logic [7:0]  wake_pflag_flags,
    output var  logic        pc_load,
    output var  logic [12:0] pc_target
);
    riv_state_t         st;
    riv_state_t         next_st;
    logic [NUM_REQ-1:0] req_s;
    logic [NUM_REQ-2:0] released;
    riv_class_t         cls;
    logic               is_reset;
    logic               is_wake;
    logic [4:0]         idx;
    logic               hit;
    logic               acc;
    logic               wr_now;

    riv_sync #(
        .WIDTH    (NUM_REQ)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({core_sleeping, int_wake_req, wdt_wake_req, wdt_req,
                    pin_req, bor_req, por_req}),
        .sync_out (req_s)
    );

    // class decode on the falling edge of each request, fixed priority
    always_comb begin
        released = st.req_prev & ~req_s[NUM_REQ-2:0];
        if (released[REQ_POR])             cls = CLS_POWER;
        else if (released[REQ_BOR])        cls = CLS_BROWN;
        else if (released[REQ_PIN])        cls = CLS_PIN;
        else if (released[REQ_WDT])        cls = CLS_WDT;
        else if (released[REQ_WWAKE])      cls = CLS_WDT_WAKE;
        else if (released[REQ_IWAKE])      cls = CLS_INT_WAKE;
        else                               cls = CLS_NONE;
        is_reset = cls inside {CLS_POWER, CLS_BROWN, CLS_PIN, CLS_WDT};
        is_wake  = cls inside {CLS_WDT_WAKE, CLS_INT_WAKE};
    end

    assign idx    = paddr[6:2];
    assign hit    = (paddr[1:0] == 2'b00) && !paddr[7] && (int'(idx) < NREG);
    assign acc    = psel && penable;
    assign wr_now = acc && st.pready && pwrite && hit && pstrb[0];

    always_comb begin
        next_st          = st;
        next_st.req_prev = req_s[NUM_REQ-2:0];
        next_st.pc_load  = 1'b0;

        // one wait state, then pready from a flop
        next_st.pready = acc && !st.pready;
        if (acc && !st.pready) begin
            next_st.pslverr = !hit;
            next_st.prdata  = hit ? {24'h000000, st.regs[idx]} : 32'h00000000;
        end
        if (wr_now) begin
            next_st.regs[idx] = (st.regs[idx] & ~WR_MASK[idx]) |
                                (pwdata[7:0] & WR_MASK[idx]);
        end

        // class application overrides a write landing in the same cycle
        if (is_reset) begin
            next_st.pc_load   = 1'b1;
            next_st.pc_target = PC_RESET;
            next_st.regs[REG_PC_LO]  = PC_RESET[7:0];
            next_st.regs[REG_PC_HI]  = 8'h00;
            next_st.regs[REG_OPTION] = VAL_ONES;
            for (int i = 0; i < NUM_TRIS; i++) begin
                next_st.regs[int'(REG_TRIS0) + i] = VAL_ONES;
            end
            next_st.regs[REG_LAT_A]  = st.regs[REG_LAT_A] & ~CLR_LAT_A;
            next_st.regs[REG_LAT_B]  = st.regs[REG_LAT_B] & ~CLR_LAT_B;
            next_st.regs[REG_INT_CTL] = {7'h00, st.regs[REG_INT_CTL][0]};
            next_st.regs[REG_PFLAG]  = 8'h00;
            next_st.regs[REG_PENAB]  = 8'h00;
            next_st.regs[REG_TXCTL]  = VAL_TXCTL;
            next_st.regs[REG_RXCTL]  = {7'h00, st.regs[REG_RXCTL][0]};
            next_st.regs[REG_CMP]    = VAL_CMP;
            next_st.regs[REG_OSC]    = VAL_OSC;
            next_st.regs[REG_WDOG]   = VAL_WDOG;
            next_st.regs[REG_LVD]    = VAL_LVD;
            next_st.regs[REG_SSP]    = 8'h00;
            next_st.regs[REG_CAPT]   = 8'h00;
            next_st.regs[REG_CONV]   = 8'h00;
            next_st.regs[REG_STATUS][7:5] = 3'b000;
        end
        unique case (cls)
            CLS_POWER, CLS_BROWN: begin
                next_st.regs[REG_STATUS][4:3] = 2'b11;
                next_st.regs[REG_T1CTL] = 8'h00;
                next_st.regs[REG_POWER][BIT_PWR_HI] = 1'b1;
                if (cls == CLS_POWER) begin
                    next_st.regs[REG_POWER][BIT_POR] = 1'b0;
                end else begin
                    next_st.regs[REG_POWER][BIT_BOR] = 1'b0;
                end
            end
            CLS_PIN: begin
                if (req_s[REQ_SLEEP]) begin
                    next_st.regs[REG_STATUS][4:3] = 2'b10;
                end
            end
            CLS_WDT: begin
                next_st.regs[REG_STATUS][4:3] = 2'b01;
            end
            CLS_WDT_WAKE, CLS_INT_WAKE: begin
                next_st.pc_load = 1'b1;
                if (cls == CLS_INT_WAKE && st.regs[REG_INT_CTL][BIT_GLB_EN]) begin
                    next_st.pc_target = PC_VECTOR;
                end else begin
                    next_st.pc_target = 13'(pc_now + PC_STEP);
                end
                next_st.regs[REG_PC_LO] = next_st.pc_target[7:0];
                next_st.regs[REG_STATUS][4:3] =
                    (cls == CLS_WDT_WAKE) ? 2'b00 : 2'b10;
                // set beats a same-cycle software clear
                next_st.regs[REG_INT_CTL] = next_st.regs[REG_INT_CTL] |
                                           wake_interrupt_control_flags;
                next_st.regs[REG_PFLAG]  = next_st.regs[REG_PFLAG] |
                                           wake_pflag_flags;
                next_st.regs[REG_TXCTL][BIT_TXIDLE] = 1'b1;
            end
            CLS_NONE: begin
            end
        endcase
        if (cls != CLS_NONE) begin
            next_st.regs[REG_PERIOD] = VAL_ONES;
            next_st.regs[REG_CLASS]  = {5'h00, cls};
        end
        // working, timer and pointer registers are never touched here
        for (int i = 0; i < NREG; i++) begin
            next_st.regs[i] = next_st.regs[i] & IMPL_MASK[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{req_prev: '0, regs: RST_IMAGE, pc_load: 1'b0,
                    pc_target: PC_RESET, pready: 1'b0, pslverr: 1'b0,
                    prdata: 32'h00000000};
        end else begin
            st <= next_st;
        end
    end

    assign prdata    = st.prdata;
    assign pready    = st.pready;
    assign pslverr   = st.pslverr;
    assign pc_load   = st.pc_load;
    assign pc_target = st.pc_target;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pc_reset_a: assert property (is_reset |=> pc_load && pc_target == 13'h0000)
        else $error("counter not cleared after reset class");
    pc_wake_a: assert property (cls == CLS_WDT_WAKE |=>
                                pc_load && pc_target == 13'($past(pc_now) + 13'h0001))
        else $error("counter not advanced on watchdog wake");
    pc_vector_a: assert property (cls == CLS_INT_WAKE && st.regs[REG_INT_CTL][7]
                                  |=> pc_target == 13'h0004)
        else $error("interrupt wake did not load vector");
    wake_flags_a: assert property (is_wake |=>
        (st.regs[REG_INT_CTL] & $past(wake_interrupt_control_flags)) == $past(wake_interrupt_control_flags))
        else $error("wake flag lost");
    status_power_a: assert property (cls inside {CLS_POWER, CLS_BROWN}
                                     |=> st.regs[REG_STATUS][7:3] == 5'b00011)
        else $error("status wrong after power class");
    status_wdt_a: assert property (cls == CLS_WDT |=> st.regs[REG_STATUS][7:3] == 5'b00001)
        else $error("status wrong after watchdog reset");
    option_ones_a: assert property (is_reset |=> st.regs[REG_OPTION] == 8'hFF
                                    && st.regs[REG_TRIS0] == 8'hFF)
        else $error("option or direction not all ones");
    period_ones_a: assert property (cls != CLS_NONE |=> st.regs[REG_PERIOD] == 8'hFF)
        else $error("period not forced");
    tx_wake_a: assert property (is_wake && !wr_now
        |=> st.regs[REG_TXCTL] == ($past(st.regs[REG_TXCTL]) | 8'h02))
        else $error("transmit control wrong after wake");
    t1_keep_a: assert property (cls inside {CLS_PIN, CLS_WDT} && !wr_now
        |=> $stable(st.regs[REG_T1CTL]))
        else $error("timer-1 control changed on pin or watchdog reset");
    por_bit_a: assert property (cls == CLS_POWER |=> st.regs[REG_POWER][2:1] == 2'b10)
        else $error("power-on status bit not cleared");
    unimpl_zero_a: assert property (pready && !pslverr && $past(idx) == REG_POWER
        |-> prdata[31:3] == 29'h0)
        else $error("unimplemented bits read nonzero");
endmodule : riv_init_ctrl
`default_nettype wire

// ===== verif/riv_cause_src.sv
/*
 * riv_cause_src: model of the reset and wake sources beside the controller.
 * Assumes the bench fires one cause at a time, several clocks apart.
 */
`timescale 1ns/1ns
`default_nettype none
module riv_cause_src (
    input  wire logic       pclk,
    input  wire logic       fire,
    input  wire logic [2:0] sel,
    input  wire logic       asleep,
    output var  logic       por_req,
    output var  logic       bor_req,
    output var  logic       pin_req,
    output var  logic       wdt_req,
    output var  logic       wdt_wake_req,
    output var  logic       int_wake_req,
    output var  logic       core_sleeping
);
    logic [5:0] lvl;
    logic [3:0] cnt;
    initial begin
        lvl = '0;
        cnt = '0;
    end
    // cause level held four clocks, then released
    always @(posedge pclk) begin
        if (fire) begin
            lvl <= 6'h01 << sel;
            cnt <= 4'h4;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) lvl <= '0;
        end
    end
    assign por_req       = lvl[0];
    assign bor_req       = lvl[1];
    assign pin_req       = lvl[2];
    assign wdt_req       = lvl[3];
    assign wdt_wake_req  = lvl[4];
    assign int_wake_req  = lvl[5];
    assign core_sleeping = asleep;
endmodule : riv_cause_src
`default_nettype wire

// ===== verif/riv_init_ctrl_tb.sv
/*
 * riv_init_ctrl_tb: self-checking bench of the initial-value controller.
 * Assumes pclk-timed APB transfers and cause levels from the partner model.
 */
`timescale 1ns/1ns
`default_nettype none
module riv_init_ctrl_tb import riv_pkg::*;;
    typedef struct packed {
        logic [4:0] ix;
        logic [7:0] wv;
        logic [7:0] ev;
    } riv_step_t;
    localparam riv_step_t PIN_ST [8] = '{
        '{REG_OPTION, 8'h5A, 8'hFF}, '{REG_TRIS0, 8'h00, 8'hFF}, '{REG_LAT_A, 8'hFF, 8'hD0},
        '{REG_INT_CTL, 8'h7F, 8'h01}, '{REG_T1CTL, 8'h55, 8'h55}, '{REG_POWER, 8'h03, 8'h03},
        '{REG_WORK, 8'hA5, 8'hA5}, '{REG_PC_HI, 8'h1F, 8'h00}};
    localparam riv_step_t WAKE_ST [8] = '{
        '{REG_OPTION, 8'h5A, 8'h5A}, '{REG_TXCTL, 8'h00, 8'h02}, '{REG_PERIOD, 8'h00, 8'hFF},
        '{REG_INT_CTL, 8'h00, 8'h02}, '{REG_PFLAG, 8'h00, 8'h10}, '{REG_TRIS0, 8'h00, 8'h00},
        '{REG_T1CTL, 8'h55, 8'h55}, '{REG_WDOG, 8'h00, 8'h00}};
    localparam riv_step_t BOR_ST [8] = '{
        '{REG_SSP, 8'hFF, 8'h00}, '{REG_RXCTL, 8'hFF, 8'h01}, '{REG_T1CTL, 8'h55, 8'h00},
        '{REG_POWER, 8'h07, 8'h06}, '{REG_PFLAG, 8'hFF, 8'h00}, '{REG_PENAB, 8'hFF, 8'h00},
        '{REG_CMP, 8'h00, 8'h07}, '{REG_LVD, 8'h00, 8'h05}};
    localparam riv_step_t POR_ST [8] = '{
        '{REG_POWER, 8'h07, 8'h05}, '{REG_STATUS, 8'hE7, 8'h1F}, '{REG_OSC, 8'h00, 8'h08},
        '{REG_WDOG, 8'h00, 8'h08}, '{REG_TXCTL, 8'hF7, 8'h02}, '{REG_T0_CNT, 8'h3C, 8'h3C},
        '{REG_PTR, 8'h77, 8'h77}, '{REG_PENAB, 8'h12, 8'h00}};
    localparam riv_step_t IMG_ST [8] = '{
        '{REG_TRIS0, 8'h0, 8'hFF}, '{5'h07, 8'h0, 8'hFF}, '{REG_PERIOD, 8'h0, 8'hFF},
        '{REG_TXCTL, 8'h0, 8'h02}, '{REG_LVD, 8'h0, 8'h05}, '{REG_POWER, 8'h0, 8'h04},
        '{REG_OPTION, 8'h0, 8'hFF}, '{REG_CLASS, 8'h0, 8'h01}};

    logic        pclk, presetn, psel, penable, pwrite, fire, asleep, rd_e;
    logic [7:0]  paddr, wake_interrupt_control_flags, wake_pflag_flags;
    logic [31:0] pwdata, prdata, rd_d;
    logic [3:0]  pstrb;
    logic [2:0]  sel;
    logic [12:0] pc_now, pc_target;
    logic        pready, pslverr, pc_load;
    wire logic   por_req, bor_req, pin_req, wdt_req, wdt_wake_req, int_wake_req, core_sleeping;
    int          mismatches, n_checks, cycles;

    riv_cause_src u_riv_cause_src (.pclk(pclk), .fire(fire), .sel(sel), .asleep(asleep),
        .por_req(por_req), .bor_req(bor_req), .pin_req(pin_req), .wdt_req(wdt_req),
        .wdt_wake_req(wdt_wake_req), .int_wake_req(int_wake_req),
        .core_sleeping(core_sleeping));
    riv_init_ctrl u_riv_init_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_req(por_req),
        .bor_req(bor_req), .pin_req(pin_req), .wdt_req(wdt_req), .wdt_wake_req(wdt_wake_req),
        .int_wake_req(int_wake_req), .core_sleeping(core_sleeping), .pc_now(pc_now),
        .wake_interrupt_control_flags(wake_interrupt_control_flags), .wake_pflag_flags(wake_pflag_flags),
        .pc_load(pc_load), .pc_target(pc_target));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic chk_byte(input string nm, input logic [7:0] ex, input logic [7:0] got);
        n_checks++;
        if (got !== ex) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk_byte
    task automatic chk_pc(input string nm, input logic [12:0] ex, input logic [12:0] got);
        n_checks++;
        if (got !== ex) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk_pc
    // one APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd_d = prdata;
        rd_e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic load(input riv_step_t s [8]);
        foreach (s[i]) apb(1'b1, {1'b0, s[i].ix, 2'b00}, s[i].wv);
    endtask : load
    task automatic verify(input riv_step_t s [8]);
        foreach (s[i]) begin
            apb(1'b0, {1'b0, s[i].ix, 2'b00}, 8'h00);
            chk_byte($sformatf("reg %0d", s[i].ix), s[i].ev, rd_d[7:0]);
        end
    endtask : verify
    task automatic rd(input logic [4:0] ix, input logic [7:0] m, input logic [7:0] ex);
        apb(1'b0, {1'b0, ix, 2'b00}, 8'h00);
        chk_byte($sformatf("reg %0d", ix), ex, rd_d[7:0] & m);
    endtask : rd
    // fire one cause, then expect a single-cycle redirect
    task automatic cause(input int s, input logic [12:0] pc);
        @(posedge pclk);
        fire <= 1'b1;
        sel  <= 3'(s);
        @(posedge pclk);
        fire <= 1'b0;
        do @(posedge pclk);
        while (pc_load !== 1'b1);
        chk_pc("pc_target", pc, pc_target);
        @(posedge pclk);
        chk_byte("pc_load", 8'h00, {7'h0, pc_load});
    endtask : cause

    task automatic t_image();
        verify(IMG_ST);
    endtask : t_image
    task automatic t_pin();
        load(PIN_ST);
        cause(REQ_PIN, 13'h0000);
        verify(PIN_ST);
        rd(REG_CLASS, 8'hFF, 8'(CLS_PIN));
    endtask : t_pin
    task automatic t_int_wake();
        load(WAKE_ST);
        asleep            <= 1'b1;
        pc_now            <= 13'h0123;
        wake_interrupt_control_flags <= 8'h02;
        wake_pflag_flags  <= 8'h10;
        cause(REQ_IWAKE, 13'h0124);
        verify(WAKE_ST);
        rd(REG_STATUS, 8'h18, 8'h10);
        apb(1'b1, {1'b0, REG_INT_CTL, 2'b00}, 8'h80);
        cause(REQ_IWAKE, 13'h0004);
        pc_now <= 13'h0FFF;
        cause(REQ_WWAKE, 13'h1000);
        rd(REG_STATUS, 8'h18, 8'h00);
        rd(REG_CLASS, 8'hFF, 8'(CLS_WDT_WAKE));
        asleep <= 1'b0;
    endtask : t_int_wake
    task automatic t_brown();
        load(BOR_ST);
        cause(REQ_BOR, 13'h0000);
        verify(BOR_ST);
    endtask : t_brown
    task automatic t_power();
        load(POR_ST);
        cause(REQ_POR, 13'h0000);
        verify(POR_ST);
    endtask : t_power
    task automatic t_wdt();
        cause(REQ_WDT, 13'h0000);
        rd(REG_STATUS, 8'hF8, 8'h08);
        rd(REG_POWER, 8'hFF, 8'h05);
        asleep <= 1'b1;
        cause(REQ_PIN, 13'h0000);
        rd(REG_STATUS, 8'hF8, 8'h10);
        rd(REG_CLASS, 8'hFF, 8'(CLS_PIN));
        asleep <= 1'b0;
    endtask : t_wdt
    task automatic t_unmapped();
        apb(1'b1, {1'b0, REG_OSC, 2'b00}, 8'hFF);
        rd(REG_OSC, 8'hFF, 8'h7F);
        apb(1'b1, {1'b0, REG_POWER, 2'b00}, 8'hFF);
        rd(REG_POWER, 8'hFF, 8'h07);
        pstrb <= 4'hE;
        apb(1'b1, {1'b0, REG_CMP, 2'b00}, 8'h3C);
        pstrb <= 4'hF;
        rd(REG_CMP, 8'hFF, 8'h07);
        apb(1'b0, 8'h80, 8'h00);
        chk_byte("unmapped", 8'h01, {7'h0, rd_e});
        chk_byte("unmapped data", 8'h00, rd_d[7:0]);
    endtask : t_unmapped

    initial begin
        {presetn, psel, penable, pwrite, fire, asleep} = '0;
        {paddr, wake_interrupt_control_flags, wake_pflag_flags, sel} = '0;
        {pwdata, pc_now} = '0;
        pstrb = 4'hF;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_image();
        t_pin();
        t_int_wake();
        t_brown();
        t_power();
        t_wdt();
        t_unmapped();
        give_verdict();
    end
endmodule : riv_init_ctrl_tb
`default_nettype wire
